//--- logic/bkreg_cfg.svh
// offsets, field positions, reset values and timing counts of the buck control bank
`ifndef BKREG_CFG_SVH
`define BKREG_CFG_SVH

// ------------------------------------------------------------
// register word indexes (byte address is four times the index)
// ------------------------------------------------------------
`define BKREG_IDX_B1_CTRL 8'h35
`define BKREG_IDX_B1_LIM 8'h36
`define BKREG_IDX_B2_RUNV 8'h38
`define BKREG_IDX_B2_STBV 8'h39
`define BKREG_IDX_B2_SLPV 8'h3A
`define BKREG_IDX_B2_CTRL 8'h3B
`define BKREG_IDX_STATE 8'h3D
`define BKREG_ADDR_W 10

// ------------------------------------------------------------
// field positions and masks
// ------------------------------------------------------------
`define BKREG_CTRL_MASK 8'hFF
`define BKREG_LIM_MASK 8'h13
`define BKREG_VOLT_MASK 8'h3F
`define BKREG_STATE_MASK 8'h03

// ------------------------------------------------------------
// fallback reset values before the fuse load
// ------------------------------------------------------------
`define BKREG_RST_CTRL 8'h00
`define BKREG_RST_LIM 8'h00
`define BKREG_RST_VOLT 8'h00

// ------------------------------------------------------------
// ramp timing
// ------------------------------------------------------------
`define BKREG_CLK_NS 5
`define BKREG_RAMP_FAST_NS 2000
`define BKREG_RAMP_SLOW_NS 4000
`define BKREG_RAMP_FAST_CYC (`BKREG_RAMP_FAST_NS / `BKREG_CLK_NS)
`define BKREG_RAMP_SLOW_CYC (`BKREG_RAMP_SLOW_NS / `BKREG_CLK_NS)

`endif

//--- logic/bkreg_pkg.sv
// types shared by the buck control bank
package bkreg_pkg;

  typedef enum logic [1:0] {
    BKREG_RUN,
    BKREG_STANDBY,
    BKREG_SLEEP,
    BKREG_OFF
  } bkreg_state_t;

  typedef struct packed {
    logic discharge_disable;
    logic force_pwm;
    logic force_ccm_on_ramp_down;
    logic slew_select;
    logic low_power;
    logic sleep_enable;
    logic standby_enable;
    logic run_enable;
  } bkreg_ctrl_t;

  typedef struct packed {
    logic enable;
    logic low_power;
    logic force_pwm;
    logic ccm_now;
    logic discharge_on;
    logic slow_ramp;
  } bkreg_drive_t;

  typedef struct packed {
    bkreg_ctrl_t b1_ctrl;
    logic [7:0] b1_limit;
    logic [5:0] b2_run;
    logic [5:0] b2_stby;
    logic [5:0] b2_slp;
    bkreg_ctrl_t b2_ctrl;
  } bkreg_fuse_t;

endpackage

//--- logic/bkreg_top.sv
// buck converter control and voltage register bank with AHB-Lite slave
//
// Behaviour
// - Each buck runs in standby only while its standby-enable bit 1 is set.
// - Each buck runs in sleep only while its sleep-enable bit 2 is set.
// - Bit 3 puts the buck into low-power operation in standby or sleep.
// - Bit 4 picks a ramp step every 2 us when 0 and every 4 us when 1.
// - The first buck's slew bit is ignored when the fuse ramp select is 1.
// - Bit 5 forces continuous conduction on the second buck while its voltage ramps down to a lower target.
// - Bit 6 holds the buck in forced PWM regardless of load.
// - A disabled buck gets its discharge resistor unless bit 7 is 1.
// - Bits 1:0 of the limit register pick the current limit, default 00.
// - Bit 4 of the limit register picks on-time (0) or off-time (1).
// - The second buck's 6-bit run voltage code sits at 0x38.
// - The second buck's standby and sleep codes sit at 0x39 and 0x3A.
// - Run-enable bit 0 is fuse-loaded, turns the buck on in run, clearable.
// - Fuse-loaded fields take their fuse value then stay read-write.
// - The first buck's control register sits at 0x35 with run-enable at 0.
`timescale 1ns/1ps
`include "bkreg_cfg.svh"

module bkreg_top #(
  parameter int RAMP_FAST_CYC = `BKREG_RAMP_FAST_CYC,
  parameter int RAMP_SLOW_CYC = `BKREG_RAMP_SLOW_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic fuse_load,
  input wire bkreg_pkg::bkreg_fuse_t fuse_values,
  input wire logic fuse_ramp_select,
  input wire bkreg_pkg::bkreg_state_t power_state,
  output bkreg_pkg::bkreg_drive_t buck1_drive,
  output bkreg_pkg::bkreg_drive_t buck2_drive,
  output logic [1:0] buck1_current_limit,
  output logic buck1_timing_mode,
  output logic [5:0] buck2_voltage_target,
  output logic [5:0] buck2_voltage_now
);

  // tick counter is 16 bits wide, so longer periods cannot be served
  if (RAMP_FAST_CYC < 1 || RAMP_SLOW_CYC < RAMP_FAST_CYC ||
      RAMP_SLOW_CYC > 65535) begin : g_ramp_range
    $error("bkreg_top: ramp counts out of range");
  end

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------
  function automatic logic [9:0] word_idx(input logic [31:0] a);
    word_idx = a[11:2];
  endfunction

  function automatic bkreg_pkg::bkreg_drive_t drive_of(
    input bkreg_pkg::bkreg_ctrl_t c,
    input bkreg_pkg::bkreg_state_t st,
    input logic falling,
    input logic fuse_sel
  );
    logic en;
    en = 1'b0;
    case (st)
      bkreg_pkg::BKREG_RUN: en = c.run_enable;
      bkreg_pkg::BKREG_STANDBY: en = c.standby_enable;
      bkreg_pkg::BKREG_SLEEP: en = c.sleep_enable;
      default: en = 1'b0;
    endcase
    drive_of.enable = en;
    drive_of.low_power = c.low_power && en &&
      (st == bkreg_pkg::BKREG_STANDBY || st == bkreg_pkg::BKREG_SLEEP);
    drive_of.force_pwm = c.force_pwm;
    drive_of.ccm_now = c.force_pwm ||
      (c.force_ccm_on_ramp_down && falling);
    drive_of.discharge_on = !en && !c.discharge_disable;
    drive_of.slow_ramp = c.slew_select && !fuse_sel;
  endfunction

  // ------------------------------------------------------------
  // bus address phase capture
  // ------------------------------------------------------------
  logic wr_pend_reg;
  logic [9:0] wr_idx_reg;
  logic [9:0] rd_idx;
  logic rd_take;
  logic wr_take;

  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  assign wr_take = hsel && hready && htrans[1] && hwrite;
  assign rd_idx = word_idx(haddr);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 10'h000;
    end else begin
      wr_pend_reg <= wr_take;
      if (wr_take) begin
        wr_idx_reg <= rd_idx;
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  bkreg_pkg::bkreg_ctrl_t b1_ctrl_reg;
  bkreg_pkg::bkreg_ctrl_t b2_ctrl_reg;
  logic [7:0] b1_lim_reg;
  logic [5:0] b2_run_reg;
  logic [5:0] b2_stby_reg;
  logic [5:0] b2_slp_reg;
  logic [7:0] wd;

  assign wd = hwdata[7:0];

  // fuse load wins over a bus write in the same cycle: the fuse image
  // must land whole at power-up
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      b1_ctrl_reg <= `BKREG_RST_CTRL;
      b2_ctrl_reg <= `BKREG_RST_CTRL;
      b1_lim_reg <= `BKREG_RST_LIM;
    end else if (fuse_load) begin
      b1_ctrl_reg <= fuse_values.b1_ctrl;
      b2_ctrl_reg <= fuse_values.b2_ctrl;
      b1_lim_reg <= fuse_values.b1_limit & `BKREG_LIM_MASK;
    end else if (wr_pend_reg) begin
      if (wr_idx_reg == 10'(`BKREG_IDX_B1_CTRL)) begin
        b1_ctrl_reg <= wd & `BKREG_CTRL_MASK;
      end
      if (wr_idx_reg == 10'(`BKREG_IDX_B2_CTRL)) begin
        b2_ctrl_reg <= wd & `BKREG_CTRL_MASK;
      end
      if (wr_idx_reg == 10'(`BKREG_IDX_B1_LIM)) begin
        b1_lim_reg <= wd & `BKREG_LIM_MASK;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      b2_run_reg <= 6'h00;
      b2_stby_reg <= 6'h00;
      b2_slp_reg <= 6'h00;
    end else if (fuse_load) begin
      b2_run_reg <= fuse_values.b2_run;
      b2_stby_reg <= fuse_values.b2_stby;
      b2_slp_reg <= fuse_values.b2_slp;
    end else if (wr_pend_reg) begin
      if (wr_idx_reg == 10'(`BKREG_IDX_B2_RUNV)) begin
        b2_run_reg <= wd[5:0];
      end
      if (wr_idx_reg == 10'(`BKREG_IDX_B2_STBV)) begin
        b2_stby_reg <= wd[5:0];
      end
      if (wr_idx_reg == 10'(`BKREG_IDX_B2_SLPV)) begin
        b2_slp_reg <= wd[5:0];
      end
    end
  end

  // ------------------------------------------------------------
  // read data, answered with no wait state
  // ------------------------------------------------------------
  logic [7:0] rd_next;

  always_comb begin
    rd_next = 8'h00;
    case (rd_idx)
      10'(`BKREG_IDX_B1_CTRL): rd_next = b1_ctrl_reg;
      10'(`BKREG_IDX_B1_LIM): rd_next = b1_lim_reg;
      10'(`BKREG_IDX_B2_RUNV): rd_next = {2'b00, b2_run_reg};
      10'(`BKREG_IDX_B2_STBV): rd_next = {2'b00, b2_stby_reg};
      10'(`BKREG_IDX_B2_SLPV): rd_next = {2'b00, b2_slp_reg};
      10'(`BKREG_IDX_B2_CTRL): rd_next = b2_ctrl_reg;
      10'(`BKREG_IDX_STATE): rd_next = {6'h00, power_state};
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata <= {24'h000000, rd_next};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // second buck voltage ramp
  // ------------------------------------------------------------
  logic [5:0] target_next;
  logic [5:0] vnow_reg;
  logic [15:0] tick_reg;
  logic [15:0] step_cyc;
  logic falling;
  logic slow2;

  always_comb begin
    case (power_state)
      bkreg_pkg::BKREG_STANDBY: target_next = b2_stby_reg;
      bkreg_pkg::BKREG_SLEEP: target_next = b2_slp_reg;
      default: target_next = b2_run_reg;
    endcase
  end

  // slew select on the second buck is not gated by the first buck's fuse
  assign slow2 = b2_ctrl_reg.slew_select;
  assign step_cyc = slow2 ? 16'(RAMP_SLOW_CYC) : 16'(RAMP_FAST_CYC);
  assign falling = vnow_reg > target_next;

  // one code step per period; a fuse load jumps straight to the fuse run code
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vnow_reg <= 6'h00;
      tick_reg <= 16'h0000;
    end else if (fuse_load) begin
      vnow_reg <= fuse_values.b2_run;
      tick_reg <= 16'h0000;
    end else if (vnow_reg == target_next) begin
      tick_reg <= 16'h0000;
    end else if (tick_reg + 16'h0001 >= step_cyc) begin
      tick_reg <= 16'h0000;
      vnow_reg <= falling ? vnow_reg - 6'h01 : vnow_reg + 6'h01;
    end else begin
      tick_reg <= tick_reg + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // registered outputs to the converters
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buck1_drive <= '0;
      buck2_drive <= '0;
      buck1_current_limit <= 2'b00;
      buck1_timing_mode <= 1'b0;
      buck2_voltage_target <= 6'h00;
      buck2_voltage_now <= 6'h00;
    end else begin
      // first buck has no ramp visible here, so no falling phase
      buck1_drive <= drive_of(b1_ctrl_reg, power_state, 1'b0,
        fuse_ramp_select);
      buck2_drive <= drive_of(b2_ctrl_reg, power_state, falling, 1'b0);
      buck1_current_limit <= b1_lim_reg[1:0];
      buck1_timing_mode <= b1_lim_reg[4];
      buck2_voltage_target <= target_next;
      buck2_voltage_now <= vnow_reg;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  standby_gate_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (power_state == bkreg_pkg::BKREG_STANDBY && !fuse_load)
      |=> buck1_drive.enable == $past(b1_ctrl_reg.standby_enable))
    else $error("standby enable not followed");

  sleep_gate_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (power_state == bkreg_pkg::BKREG_SLEEP)
      |=> buck2_drive.enable == $past(b2_ctrl_reg.sleep_enable))
    else $error("sleep enable not followed");

  low_power_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (power_state == bkreg_pkg::BKREG_RUN) |=> !buck1_drive.low_power)
    else $error("low power seen in run");

  slew_gate_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    fuse_ramp_select |=> !buck1_drive.slow_ramp)
    else $error("slew bit used despite fuse select");

  ccm_ramp_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (falling && b2_ctrl_reg.force_ccm_on_ramp_down) |=> buck2_drive.ccm_now)
    else $error("no forced conduction on falling ramp");

  discharge_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $past(hresetn) |-> buck2_drive.discharge_on ==
      (!buck2_drive.enable && !$past(b2_ctrl_reg.discharge_disable)))
    else $error("discharge not following its bit");

  limit_write_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_pend_reg && !fuse_load && wr_idx_reg == 10'(`BKREG_IDX_B1_LIM))
      |=> ##1 buck1_current_limit == $past(wd[1:0], 2))
    else $error("current limit write lost");

  unused_zero_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (b1_lim_reg[7:5] == 3'b000) && (b1_lim_reg[3:2] == 2'b00))
    else $error("unused limit bits set");

  run_voltage_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_pend_reg && !fuse_load && wr_idx_reg == 10'(`BKREG_IDX_B2_RUNV))
      |=> b2_run_reg == $past(wd[5:0]))
    else $error("run voltage write lost");

  timing_mode_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_pend_reg && !fuse_load && wr_idx_reg == 10'(`BKREG_IDX_B1_LIM))
      |=> ##1 buck1_timing_mode == $past(wd[4], 2))
    else $error("timing mode write lost");

  standby_volt_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_pend_reg && !fuse_load && wr_idx_reg == 10'(`BKREG_IDX_B2_STBV))
      |=> b2_stby_reg == $past(wd[5:0]))
    else $error("standby voltage write lost");

  force_pwm_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    b1_ctrl_reg.force_pwm |=> buck1_drive.force_pwm && buck1_drive.ccm_now)
    else $error("forced pwm not applied");

  run_gate_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (power_state == bkreg_pkg::BKREG_RUN)
      |=> buck2_drive.enable == $past(b2_ctrl_reg.run_enable))
    else $error("run enable not followed");

endmodule

//--- tb/testbench.sv
// self-checking bench for the buck control register bank
`timescale 1ns/1ps

module testbench;
  // ------------------------------------------------------------
  // stimulus, model state and design hookup
  // ------------------------------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic fuse_load = 1'b0;
  bkreg_pkg::bkreg_fuse_t fuse_values = '0;
  logic fuse_ramp_select = 1'b0;
  bkreg_pkg::bkreg_state_t power_state = bkreg_pkg::BKREG_RUN;
  bkreg_pkg::bkreg_drive_t buck1_drive;
  bkreg_pkg::bkreg_drive_t buck2_drive;
  logic [1:0] buck1_current_limit;
  logic buck1_timing_mode;
  logic [5:0] buck2_voltage_target;
  logic [5:0] buck2_voltage_now;
  int error_cnt = 0;
  int compares = 0;
  int seed = 85;
  int n;
  logic [31:0] got;
  int m [6] = '{0, 0, 0, 0, 0, 0};
  int mask [6] = '{'hFF, 'h13, 'h3F, 'h3F, 'h3F, 'hFF};
  int idx [6] = '{'h35, 'h36, 'h38, 'h39, 'h3A, 'h3B};

  always #2.5 hclk = ~hclk;
  assign hready = hreadyout;

  // short ramp periods keep the run brief
  bkreg_top #(.RAMP_FAST_CYC(2), .RAMP_SLOW_CYC(4)) i_bkreg_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .fuse_load(fuse_load), .fuse_values(fuse_values),
    .fuse_ramp_select(fuse_ramp_select), .power_state(power_state),
    .buck1_drive(buck1_drive), .buck2_drive(buck2_drive),
    .buck1_current_limit(buck1_current_limit),
    .buck1_timing_mode(buck1_timing_mode),
    .buck2_voltage_target(buck2_voltage_target),
    .buck2_voltage_now(buck2_voltage_now)
  );

  // ------------------------------------------------------------
  // reporting
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t read got %0h exp %0h", $time, g, e);
    end
  endtask

  task automatic chk_out(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t output got %0h exp %0h", $time, g, e);
    end
  endtask

  task automatic give_up(input int cnt, input int lim);
    if (cnt >= lim) begin
      error_cnt++;
      finish_test();
    end
  endtask

  // ------------------------------------------------------------
  // bus master: called just after a rising edge
  // ------------------------------------------------------------
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    give_up((hready !== 1'b1) ? 50 : 0, 50);
  endtask

  task automatic ahb_wr(input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b1;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic ahb_rd(input logic [31:0] a, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b0;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    wait_rdy();
    d = hrdata;
  endtask

  task automatic wr_reg(input int i, input int d);
    ahb_wr(32'(idx[i]) << 2, 32'(d));
    m[i] = d & mask[i];
  endtask

  task automatic rd_chk(input int i);
    logic [31:0] g;
    ahb_rd(32'(idx[i]) << 2, g);
    chk_rd(g, 32'(m[i]));
  endtask

  // ------------------------------------------------------------
  // reference model of the converter controls
  // ------------------------------------------------------------
  function automatic logic [5:0] exp_drv(input int c, input int st,
                                         input bit b1);
    logic en;
    logic lp;
    en = (st == 0) ? c[0] : (st == 1) ? c[1] : (st == 2) ? c[2] : 1'b0;
    lp = c[3] && en && (st == 1 || st == 2);
    // the fuse ramp option only gates the first converter
    return {en, lp, c[6], c[6], !en && !c[7],
            c[4] && !(b1 && fuse_ramp_select)};
  endfunction

  task automatic chk_drives();
    int st;
    repeat (3) @(posedge hclk);
    st = int'(power_state);
    chk_out(buck1_drive, exp_drv(m[0], st, 1'b1));
    chk_out(buck2_drive, exp_drv(m[5], st, 1'b0));
    chk_out(buck1_current_limit, m[1] & 3);
    chk_out(buck1_timing_mode, (m[1] >> 4) & 1);
    // off state keeps the run code as target
    chk_out(buck2_voltage_target, m[(st == 3) ? 2 : 2 + st]);
  endtask

  task automatic wait_now(input bit probe, input bit ccm, output int c);
    c = 0;
    // target output lags the register by an edge: let the new code show
    repeat (2) @(posedge hclk);
    while (buck2_voltage_now !== buck2_voltage_target && c < 600) begin
      @(posedge hclk);
      c++;
      if (probe && c == 10) begin
        @(negedge hclk);
        chk_out(buck2_drive.ccm_now, ccm);
      end
    end
    give_up(c, 600);
  endtask

  task automatic ramp(input int code, input bit ccm, input int p);
    int d;
    int c;
    d = (code > m[2]) ? code - m[2] : m[2] - code;
    wr_reg(2, code);
    wait_now(1'b1, ccm, c);
    chk_out(c >= d * p - p && c <= d * p + p + 4, 1);
    chk_drives();
  endtask

  task automatic fuse_pulse();
    logic [63:0] r;
    bkreg_pkg::bkreg_fuse_t f;
    r = {$random(seed), $random(seed)};
    f = r[41:0];
    f.b1_ctrl.standby_enable = f.b1_ctrl.run_enable;
    f.b2_ctrl.standby_enable = f.b2_ctrl.run_enable;
    m = '{f.b1_ctrl, f.b1_limit & 8'h13, f.b2_run, f.b2_stby, f.b2_slp,
          f.b2_ctrl};
    fuse_values <= f;
    fuse_load <= 1'b1;
    @(posedge hclk);
    fuse_load <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge hclk);
    give_up(1, 1);
  end

  initial begin
    repeat (6) @(posedge hclk);
    chk_out({hreadyout, hresp, buck1_drive}, 32'h80);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 6; i++) begin
      rd_chk(i);
    end
    fuse_pulse();
    chk_out(buck2_voltage_now, m[2]);
    for (int i = 0; i < 6; i++) begin
      rd_chk(i);
    end
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 6; i++) begin
        wr_reg(i, $random(seed));
      end
      ahb_wr(32'hF0, $random(seed));
      for (int i = 0; i < 6; i++) begin
        rd_chk(i);
      end
      ahb_rd(32'hDC, got);
      chk_rd(got, 32'h0);
    end
    // equal codes so that state changes do not start a ramp
    wr_reg(3, 8'h08);
    wr_reg(4, 8'h08);
    wr_reg(2, 8'h08);
    wait_now(1'b0, 1'b0, n);
    for (int k = 0; k < 24; k++) begin
      power_state <= bkreg_pkg::bkreg_state_t'(k % 4);
      fuse_ramp_select <= 1'((k / 4) % 2);
      wr_reg(0, $random(seed));
      wr_reg(5, $random(seed) & 'hDF);
      wr_reg(1, $random(seed));
      chk_drives();
      ahb_rd(32'hF4, got);
      chk_rd(got, 32'(k % 4));
    end
    power_state <= bkreg_pkg::BKREG_RUN;
    wr_reg(5, 8'h21);
    ramp(8'h1C, 1'b0, 2);
    wr_reg(5, 8'h31);
    ramp(8'h08, 1'b1, 4);
    finish_test();
  end
endmodule
